/* byte_load_pkg.sv */
package byte_load_pkg;

    // Opcode values of the byte-load group.
    localparam logic [7:0] OP_MOVE_RR = 8'hE4;
    localparam logic [7:0] OP_MOVE_RIR = 8'hE5;
    localparam logic [7:0] OP_MOVE_RIM = 8'hE6;
    localparam logic [7:0] OP_MOVE_IRIM = 8'hD6;
    localparam logic [7:0] OP_MOVE_IRR = 8'hF5;
    localparam logic [7:0] OP_MOVE_RIND = 8'hC7;
    localparam logic [7:0] OP_MOVE_INDR = 8'hD7;
    localparam logic [7:0] OP_MOVE_XLD = 8'h87;
    localparam logic [7:0] OP_MOVE_XST = 8'h97;
    localparam logic [3:0] LO_MOVE_IM = 4'hC;
    localparam logic [3:0] LO_MOVE_LD = 4'h8;
    localparam logic [3:0] LO_MOVE_ST = 4'h9;
    localparam logic [7:0] OP_PTR_LD = 8'hC3;
    localparam logic [7:0] OP_PTR_ST = 8'hD3;
    localparam logic [7:0] OP_SHORT_LD = 8'hE7;
    localparam logic [7:0] OP_SHORT_ST = 8'hF7;
    localparam logic [7:0] OP_LONG_LD = 8'hA7;
    localparam logic [7:0] OP_LONG_ST = 8'hB7;
    // Low nibbles that turn a long-offset opcode into a direct-address one.
    localparam logic [3:0] DIRECT_PROG_NIB = 4'h0;
    localparam logic [3:0] DIRECT_DATA_NIB = 4'h1;

    // Working registers occupy this page of the register file.
    localparam logic [3:0] WORK_PAGE = 4'hC;

    // Execution times in CPU cycles per format.
    localparam logic [4:0] CYC_MOVE_SHORT = 5'h04;
    localparam logic [4:0] CYC_MOVE_LONG = 5'h06;
    localparam logic [4:0] CYC_PTR = 5'h0A;
    localparam logic [4:0] CYC_SHORT = 5'h0C;
    localparam logic [4:0] CYC_LONG = 5'h0E;

    // Instruction lengths in bytes.
    localparam logic [2:0] LEN_TWO = 3'h2;
    localparam logic [2:0] LEN_THREE = 3'h3;
    localparam logic [2:0] LEN_FOUR = 3'h4;

    // Register file size.
    localparam int REG_COUNT = 256;

endpackage

/* byte_load_unit.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Move copies source byte; source stays unchanged
// - No flag bit changes for moves or loads
// - Memory transfer moves one byte, either direction
// - Even pair program memory, odd pair data
// - Direct nibble 0 program, 1 data; address
// - Program memory writes only on programmable parts
module byte_load_unit #(
    parameter bit PROGRAMMABLE = 1'b1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Instruction issue: all bytes present when start pulses.
    input wire logic start,
    input wire logic [7:0] op_byte,
    input wire logic [7:0] arg1,
    input wire logic [7:0] arg2,
    input wire logic [7:0] arg3,
    // Flag register passed through.
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out,
    // Memory port.
    output logic mem_req,
    output logic mem_we,
    output logic mem_sel_data,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Status.
    output logic busy,
    output logic done,
    output logic illegal,
    output logic [2:0] inst_len,
    // Register file observation.
    input wire logic [7:0] dbg_addr,
    output logic [7:0] dbg_data
);

    //////////////////////////////////////////////////////////////////////
    // Decode.
    //////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {IDLE, WAIT, MEMRD, FINISH} state_e;

    logic [7:0] regs_q [byte_load_pkg::REG_COUNT];
    state_e state_q;
    logic [4:0] cnt_q;
    logic [7:0] op_q, a1_q, a2_q, a3_q;

    wire known, is_mem, mem_store, mem_data;
    wire [1:0] mem_mode;
    wire [2:0] length;
    wire [4:0] cycles;

    load_decode dec (
        .opcode(op_byte),
        .operand(arg1),
        .known(known),
        .is_mem(is_mem),
        .mem_store(mem_store),
        .mem_data(mem_data),
        .mem_mode(mem_mode),
        .length(length),
        .cycles(cycles)
    );

    // Working register r maps to address page C.
    function automatic logic [7:0] wr(input logic [3:0] r);
        wr = {byte_load_pkg::WORK_PAGE, r};
    endfunction

    // Operand fields of the captured instruction.
    wire [3:0] hi_n = a1_q[7:4];
    wire [3:0] lo_n = a1_q[3:0];
    wire [3:0] op_hi = op_q[7:4];
    wire [3:0] op_lo = op_q[3:0];
    // Pointer pair forced even for the pair's high register.
    wire [7:0] pair_hi_a = wr({lo_n[3:1], 1'b0});
    wire [7:0] pair_lo_a = wr({lo_n[3:1], 1'b1});
    wire [15:0] pair_val = {regs_q[pair_hi_a], regs_q[pair_lo_a]};
    wire [15:0] short_off = {{8{a2_q[7]}}, a2_q};
    wire [15:0] long_off = {a3_q, a2_q};
    // Class of the captured instruction, kept from the decoder so it cannot drift while the bytes sit.
    logic is_mem_q, store_q, sel_q;
    logic [1:0] mode_q;
    wire [15:0] eff_addr = (mode_q == 2'h3) ? long_off
        : (mode_q == 2'h2) ? 16'(pair_val + long_off)
        : (mode_q == 2'h1) ? 16'(pair_val + short_off) : pair_val;
    // Program memory writes are refused on mask-ROM builds.
    wire store_blocked = store_q && !lo_n[0] && !PROGRAMMABLE;

    //////////////////////////////////////////////////////////////////////
    // Register move source and destination.
    //////////////////////////////////////////////////////////////////////

    // Indexed moves: 87 loads dst from x[src]; 97 stores src to x[dst].
    wire [7:0] idx_ld = 8'(a2_q + regs_q[wr(lo_n)]);
    wire [7:0] idx_st = 8'(a2_q + regs_q[wr(lo_n)]);
    logic [7:0] mv_dst, mv_val;
    always_comb begin
        mv_dst = 8'h00;
        mv_val = 8'h00;
        if (op_lo == byte_load_pkg::LO_MOVE_IM) begin
            mv_dst = wr(op_hi);
            mv_val = a1_q;
        end else if (op_lo == byte_load_pkg::LO_MOVE_LD) begin
            mv_dst = wr(op_hi);
            mv_val = regs_q[a1_q];
        end else if (op_lo == byte_load_pkg::LO_MOVE_ST) begin
            mv_dst = a1_q;
            mv_val = regs_q[wr(op_hi)];
        end else begin
            case (op_q)
                byte_load_pkg::OP_MOVE_RIND: begin
                    mv_dst = wr(hi_n);
                    mv_val = regs_q[regs_q[wr(lo_n)]];
                end
                byte_load_pkg::OP_MOVE_INDR: begin
                    mv_dst = regs_q[wr(hi_n)];
                    mv_val = regs_q[wr(lo_n)];
                end
                byte_load_pkg::OP_MOVE_RR: begin
                    mv_dst = a2_q;
                    mv_val = regs_q[a1_q];
                end
                byte_load_pkg::OP_MOVE_RIR: begin
                    mv_dst = a2_q;
                    mv_val = regs_q[regs_q[a1_q]];
                end
                byte_load_pkg::OP_MOVE_RIM: begin
                    mv_dst = a1_q;
                    mv_val = a2_q;
                end
                byte_load_pkg::OP_MOVE_IRIM: begin
                    mv_dst = regs_q[a1_q];
                    mv_val = a2_q;
                end
                byte_load_pkg::OP_MOVE_IRR: begin
                    mv_dst = regs_q[a2_q];
                    mv_val = regs_q[a1_q];
                end
                byte_load_pkg::OP_MOVE_XLD: begin
                    mv_dst = wr(hi_n);
                    mv_val = regs_q[idx_ld];
                end
                default: begin
                    mv_dst = idx_st;
                    mv_val = regs_q[wr(hi_n)];
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Sequencer.
    //////////////////////////////////////////////////////////////////////

    wire take = (state_q == IDLE) && start && known;
    wire count_end = (state_q == WAIT) && (cnt_q == 5'h02);

    // Holds the instruction bytes and counts down its execution time.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= IDLE;
            cnt_q <= 5'h00;
            op_q <= 8'h00;
            a1_q <= 8'h00;
            a2_q <= 8'h00;
            a3_q <= 8'h00;
            is_mem_q <= 1'b0;
            store_q <= 1'b0;
            sel_q <= 1'b0;
            mode_q <= 2'h0;
        end else begin
            case (state_q)
                IDLE: begin
                    if (take) begin
                        state_q <= WAIT;
                        cnt_q <= cycles;
                        op_q <= op_byte;
                        a1_q <= arg1;
                        a2_q <= arg2;
                        a3_q <= arg3;
                        is_mem_q <= is_mem;
                        store_q <= mem_store;
                        sel_q <= mem_data;
                        mode_q <= mem_mode;
                    end
                end
                WAIT: begin
                    cnt_q <= 5'(cnt_q - 5'h01);
                    if (count_end) begin
                        state_q <= is_mem_q && !store_q ? MEMRD : FINISH;
                    end
                end
                MEMRD: state_q <= FINISH;
                default: state_q <= IDLE;
            endcase
        end
    end

    // Memory request is decided in the last WAIT cycle and shows on mem_req the next cycle; read data captured in MEMRD.
    wire mem_fire = count_end && is_mem_q && !store_blocked;
    wire mv_write = count_end && !is_mem_q;
    wire ld_write = (state_q == MEMRD);

    // The register file: only the destination byte ever changes.
    always_ff @(posedge sys_clk) begin
        if (mv_write) begin
            regs_q[mv_dst] <= mv_val;
        end else if (ld_write) begin
            regs_q[wr(hi_n)] <= mem_rdata;
        end
    end

    // Port outputs, all registered.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_sel_data <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
            inst_len <= 3'h0;
            flags_out <= 8'h00;
            dbg_data <= 8'h00;
        end else begin
            mem_req <= mem_fire;
            mem_we <= mem_fire && store_q;
            mem_sel_data <= lo_n[0];
            mem_addr <= eff_addr;
            mem_wdata <= regs_q[wr(hi_n)];
            busy <= take || ((state_q != IDLE) && (state_q != FINISH));
            done <= (state_q == WAIT && count_end && !(is_mem_q && !store_q)) || ld_write;
            illegal <= (state_q == IDLE) && start && !known;
            inst_len <= take ? length : inst_len;
            flags_out <= flags_in;
            dbg_data <= regs_q[dbg_addr];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Checks.
    //////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    flags_kept_a: assert property (##1 flags_out == $past(flags_in)) else $error("flags changed");
    ptr_timing_a: assert property ((take && (op_byte == byte_load_pkg::OP_PTR_ST)) |-> ##10 mem_req)
        else $error("pointer store not at cycle 10");
    short_timing_a: assert property ((take && (op_byte == byte_load_pkg::OP_SHORT_ST)) |-> ##12 mem_req)
        else $error("short store timing");
    move_timing_a: assert property ((take && (cycles == byte_load_pkg::CYC_MOVE_SHORT)) |-> ##4 done)
        else $error("move timing");
    len_short_a: assert property ((take && (op_byte == byte_load_pkg::OP_SHORT_LD)) |=> inst_len == 3'h3)
        else $error("short length");
    len_long_a: assert property ((take && (op_byte == byte_load_pkg::OP_LONG_ST) && arg1[3:1] != 3'h0)
        |=> inst_len == 3'h4) else $error("long length");
    space_sel_a: assert property (mem_req |-> mem_sel_data == sel_q) else $error("space select");
    rom_guard_a: assert property ((mem_req && mem_we && !mem_sel_data) |-> PROGRAMMABLE)
        else $error("rom write");
    store_data_a: assert property (mem_we |-> mem_req) else $error("write without request");

    move_seen_c: cover property (mv_write);
    load_seen_c: cover property (ld_write);
    store_seen_c: cover property (mem_req && mem_we);
    bad_seen_c: cover property (illegal);

endmodule

`default_nettype wire

/* byte_load_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module byte_load_unit_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [7:0] op_byte = 8'h00, arg1 = 8'h00, arg2 = 8'h00, arg3 = 8'h00, flags_in = 8'h00;
    logic [7:0] dbg_addr = 8'h00;
    logic [7:0] flags_out, mem_wdata, mem_rdata, dbg_data;
    logic mem_req, mem_we, mem_sel_data, busy, done, illegal;
    logic [15:0] mem_addr;
    logic [2:0] inst_len;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] rf [256]; // Reference register file.
    logic [7:0] ref_mem [int]; // Reference of bytes written to memory.
    logic req_seen, we_seen, sel_seen; // Captured memory request.
    logic [15:0] addr_seen;
    logic [7:0] wdata_seen;
    int req_cyc;
    localparam logic [7:0] mem_ops [8] = '{byte_load_pkg::OP_PTR_LD, byte_load_pkg::OP_PTR_ST,
        byte_load_pkg::OP_SHORT_LD, byte_load_pkg::OP_SHORT_ST, byte_load_pkg::OP_LONG_LD,
        byte_load_pkg::OP_LONG_ST, byte_load_pkg::OP_LONG_LD, byte_load_pkg::OP_LONG_ST};

    byte_load_unit DUT (.sys_clk(sys_clk), .rst(rst), .start(start), .op_byte(op_byte), .arg1(arg1),
        .arg2(arg2), .arg3(arg3), .flags_in(flags_in), .flags_out(flags_out), .mem_req(mem_req),
        .mem_we(mem_we), .mem_sel_data(mem_sel_data), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .busy(busy), .done(done), .illegal(illegal), .inst_len(inst_len),
        .dbg_addr(dbg_addr), .dbg_data(dbg_data));
    memory_partner partner (.sys_clk(sys_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_sel_data(mem_sel_data), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    //////////////////////////////////////////////////////////////////////////
    // Clock of 5 ns.
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        checks++;
        if (seen !== expected) begin
            mismatches++;
            $display("mismatch at %0t ns: seen %h, expected %h", $time, seen, expected);
        end
    endtask

    // Reads one register through the observation port; its data is one cycle late.
    task automatic peek(input logic [7:0] a);
        dbg_addr = a;
        @(posedge sys_clk);
        #1;
        check(dbg_data, rf[a]);
    endtask

    // Issues one instruction a cycle after the last done, then times it up to its done.
    task automatic run(input logic [7:0] op, a1, a2, a3, input int n, input logic [2:0] len);
        int cnt;
        logic [7:0] fl;
        fl = 8'($urandom);
        req_seen = 1'b0;
        @(posedge sys_clk);
        #1;
        start = 1'b1;
        {op_byte, arg1, arg2, arg3} = {op, a1, a2, a3};
        flags_in = fl;
        @(posedge sys_clk);
        #1;
        start = 1'b0;
        // Bytes are only promised with start, so scramble them afterwards.
        {op_byte, arg1, arg2, arg3} = $urandom;
        cnt = 1;
        check(busy, 1'b1);
        while (done !== 1'b1 && cnt < 40) begin
            @(posedge sys_clk);
            #1;
            cnt++;
            if (mem_req === 1'b1) begin
                {req_seen, req_cyc, we_seen, sel_seen} = {1'b1, cnt, mem_we, mem_sel_data};
                {addr_seen, wdata_seen} = {mem_addr, mem_wdata};
            end
        end
        check(16'(cnt), 16'(n));
        check(16'(inst_len), 16'(len));
        check(flags_out, fl);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 1300 cycles, so 20000 means a hang.
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        int unsigned seed;
        logic [7:0] v, a2, a3;
        logic [3:0] r, p;
        logic [15:0] base, addr;
        logic st, sel;
        int k, n, key;
        logic [2:0] len;
        seed = $urandom(58);
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        check({busy, done, mem_req, illegal}, 4'h0);
        $display("test reset done");
        // Immediate loads fill all working registers.
        for (int i = 0; i < 16; i++) begin
            v = 8'($urandom);
            run({4'(i), byte_load_pkg::LO_MOVE_IM}, v, 8'h00, 8'h00, 4, 3'h2);
            rf[{4'hC, 4'(i)}] = v;
        end
        for (int i = 0; i < 16; i++) peek({4'hC, 4'(i)});
        // Register to register moves in both widths; sources are read back afterwards.
        v = 8'($urandom);
        run(byte_load_pkg::OP_MOVE_RIM, 8'h40, v, 8'h00, 6, 3'h3);
        rf[8'h40] = v;
        run(byte_load_pkg::OP_MOVE_RR, 8'h40, 8'h41, 8'h00, 6, 3'h3);
        rf[8'h41] = rf[8'h40];
        run({4'h5, byte_load_pkg::LO_MOVE_LD}, 8'h41, 8'h00, 8'h00, 4, 3'h2);
        rf[8'hC5] = rf[8'h41];
        run({4'h6, byte_load_pkg::LO_MOVE_ST}, 8'h42, 8'h00, 8'h00, 4, 3'h2);
        rf[8'h42] = rf[8'hC6];
        // Indirect and indexed move forms, pointing through register 43 and r7.
        run(byte_load_pkg::OP_MOVE_RIM, 8'h43, 8'h40, 8'h00, 6, 3'h3);
        rf[8'h43] = 8'h40;
        run({4'h7, byte_load_pkg::LO_MOVE_IM}, 8'h42, 8'h00, 8'h00, 4, 3'h2);
        rf[8'hC7] = 8'h42;
        run(byte_load_pkg::OP_MOVE_RIR, 8'h43, 8'h44, 8'h00, 6, 3'h3);
        rf[8'h44] = rf[rf[8'h43]];
        v = 8'($urandom);
        run(byte_load_pkg::OP_MOVE_IRIM, 8'h43, v, 8'h00, 6, 3'h3);
        rf[rf[8'h43]] = v;
        peek(rf[8'h43]);
        run(byte_load_pkg::OP_MOVE_IRR, 8'h41, 8'h43, 8'h00, 6, 3'h3);
        rf[rf[8'h43]] = rf[8'h41];
        run(byte_load_pkg::OP_MOVE_RIND, 8'h87, 8'h00, 8'h00, 4, 3'h2);
        rf[8'hC8] = rf[rf[8'hC7]];
        run(byte_load_pkg::OP_MOVE_INDR, 8'h79, 8'h00, 8'h00, 4, 3'h2);
        rf[rf[8'hC7]] = rf[8'hC9];
        run(byte_load_pkg::OP_MOVE_XLD, 8'hA7, 8'hFE, 8'h00, 6, 3'h3);
        rf[8'hCA] = rf[8'(8'hFE + rf[8'hC7])];
        run(byte_load_pkg::OP_MOVE_XST, 8'hB7, 8'h03, 8'h00, 6, 3'h3);
        rf[8'(8'h03 + rf[8'hC7])] = rf[8'hCB];
        foreach (rf[a]) if (a inside {[8'h40:8'h45], [8'hC5:8'hCB]}) peek(8'(a));
        $display("test moves done");
        // All memory forms, loads and stores, both spaces.
        for (int i = 0; i < 64; i++) begin
            k = i % 8;
            {r, p, a2, a3} = $urandom;
            if (k == 4 || k == 5) p = 4'(2 + $urandom % 14);
            if (k >= 6) {p, a2, a3} = {3'h0, p[0], 6'h00, a2[1:0], 8'h12};
            base = {rf[{4'hC, p[3:1], 1'b0}], rf[{4'hC, p[3:1], 1'b1}]};
            sel = p[0];
            st = k[0];
            case (k / 2)
                0: {addr, n, len} = {base, 32'd10, 3'h2};
                1: {addr, n, len} = {base + {{8{a2[7]}}, a2}, 32'd12, 3'h3};
                2: {addr, n, len} = {base + {a3, a2}, 32'd14, 3'h4};
                default: {addr, n, len} = {a3, a2, 32'd14, 3'h4};
            endcase
            run(mem_ops[k], {r, p}, a2, a3, st ? n : n + 1, len);
            check(16'(req_cyc), 16'(n));
            check({req_seen, we_seen, sel_seen}, {1'b1, st, sel});
            check(addr_seen, addr);
            key = int'({sel, addr});
            if (st) begin
                check(wdata_seen, rf[{4'hC, r}]);
                ref_mem[key] = rf[{4'hC, r}];
            end else if (ref_mem.exists(key)) begin
                rf[{4'hC, r}] = ref_mem[key];
            end else begin
                rf[{4'hC, r}] = addr[7:0] ^ {addr[11:8], addr[15:12]} ^ (sel ? 8'hA5 : 8'h3C);
            end
            peek({4'hC, r});
            peek({4'hC, p[3:1], 1'b0});
            peek({4'hC, p[3:1], 1'b1});
        end
        for (int i = 0; i < 16; i++) peek({4'hC, 4'(i)});
        $display("test memory done");
        // An opcode outside the group is refused with a pulse.
        @(posedge sys_clk);
        #1;
        start = 1'b1;
        op_byte = 8'h00;
        @(posedge sys_clk);
        #1;
        start = 1'b0;
        check({illegal, busy}, 2'h2);
        $display("test refusal done");
        report_and_stop();
    end
endmodule
`default_nettype wire

/* load_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// Pure decoder: from the opcode byte and the operand byte it yields the
// instruction length, execution time and the addressing choices.
module load_decode (
    // Instruction bytes.
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand,
    // Decoded class.
    output logic known,
    output logic is_mem,
    output logic mem_store,
    output logic mem_data,
    output logic [1:0] mem_mode,
    output logic [2:0] length,
    output logic [4:0] cycles
);

    // Memory forms: 0 pointer, 1 short offset, 2 long offset, 3 direct.
    wire op_ptr = (opcode == byte_load_pkg::OP_PTR_LD) || (opcode == byte_load_pkg::OP_PTR_ST);
    wire op_short = (opcode == byte_load_pkg::OP_SHORT_LD) || (opcode == byte_load_pkg::OP_SHORT_ST);
    wire op_long = (opcode == byte_load_pkg::OP_LONG_LD) || (opcode == byte_load_pkg::OP_LONG_ST);
    // A zero or one low nibble means direct addressing, since pair 0-1 is banned as pointer.
    wire op_direct = op_long && (operand[3:1] == 3'h0);
    wire lo_move = (opcode[3:0] == byte_load_pkg::LO_MOVE_IM) || (opcode[3:0] == byte_load_pkg::LO_MOVE_LD)
        || (opcode[3:0] == byte_load_pkg::LO_MOVE_ST);
    wire three_move = (opcode == byte_load_pkg::OP_MOVE_RR) || (opcode == byte_load_pkg::OP_MOVE_RIR)
        || (opcode == byte_load_pkg::OP_MOVE_RIM) || (opcode == byte_load_pkg::OP_MOVE_IRIM)
        || (opcode == byte_load_pkg::OP_MOVE_IRR) || (opcode == byte_load_pkg::OP_MOVE_XLD)
        || (opcode == byte_load_pkg::OP_MOVE_XST);
    wire two_move = lo_move || (opcode == byte_load_pkg::OP_MOVE_RIND) || (opcode == byte_load_pkg::OP_MOVE_INDR);

    assign is_mem = op_ptr || op_short || op_long;
    assign known = is_mem || three_move || two_move;
    assign mem_store = opcode[4];
    // Direct forms pick the space from the nibble, pointer forms from pair parity.
    assign mem_data = operand[0];
    assign mem_mode = op_ptr ? 2'h0 : op_short ? 2'h1 : op_direct ? 2'h3 : 2'h2;
    assign cycles = op_ptr ? byte_load_pkg::CYC_PTR : op_short ? byte_load_pkg::CYC_SHORT
        : op_long ? byte_load_pkg::CYC_LONG : three_move ? byte_load_pkg::CYC_MOVE_LONG
        : byte_load_pkg::CYC_MOVE_SHORT;
    assign length = op_long ? byte_load_pkg::LEN_FOUR : (op_short || three_move)
        ? byte_load_pkg::LEN_THREE : byte_load_pkg::LEN_TWO;

endmodule

`default_nettype wire

/* memory_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// Program and external data memory seen by the unit; unwritten bytes follow a fixed pattern.
module memory_partner (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Access request from the unit.
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_sel_data,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    // Read data back to the unit.
    output logic [7:0] mem_rdata
);
    logic [7:0] bytes_q [int]; // Written bytes, keyed by space and address.
    logic [7:0] hold_q; // Data of the last read.
    logic hold_valid_q; // Read data still owed for one cycle.
    logic [7:0] now_data; // Byte at the address on the bus now.
    logic rd_req; // A read is being asked for.

    //////////////////////////////////////////////////////////////////////////
    // The select bit keeps the two spaces apart.
    assign rd_req = mem_req && !mem_we;
    always @* begin
        if (bytes_q.exists({mem_sel_data, mem_addr})) begin
            now_data = bytes_q[{mem_sel_data, mem_addr}];
        end else begin
            now_data = mem_addr[7:0] ^ {mem_addr[11:8], mem_addr[15:12]} ^ (mem_sel_data ? 8'hA5 : 8'h3C);
        end
    end

    // Data is valid in the request cycle and the one after; otherwise the bus shows the inverse,
    // so a late sample cannot pass by luck.
    assign mem_rdata = rd_req ? now_data : (hold_valid_q ? hold_q : ~hold_q);

    // One byte is stored per write request.
    always @(posedge sys_clk) begin
        hold_valid_q <= !rst && rd_req;
        if (rd_req) begin
            hold_q <= now_data;
        end
        if (!rst && mem_req && mem_we) begin
            bytes_q[{mem_sel_data, mem_addr}] = mem_wdata;
        end
    end
endmodule
`default_nettype wire
